/* File: logic/t1ras_carrier.sv */
// carrier loss detector: zero run sets, ones in a window clear
`timescale 1ns/1ps
module t1ras_carrier (
    input wire logic clk,
    input wire logic nrst,
    input wire logic bit_en,
    input wire logic mark,
    output logic loss
);
    import t1ras_pkg::*;
    logic [7:0] zero_reg;
    logic [6:0] win_reg;
    logic [3:0] ones_reg;
    logic open_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            loss <= 1'b0;
            zero_reg <= 8'h00;
            win_reg <= 7'h00;
            ones_reg <= 4'h0;
            open_reg <= 1'b0;
        end else if (bit_en && !loss) begin
            if (mark) begin
                zero_reg <= 8'h00;
            end else if (zero_reg == 8'(CARRIER_ZEROS - 1)) begin
                loss <= 1'b1; // RULE4 RULE10
                zero_reg <= 8'h00;
                open_reg <= 1'b0;
            end else begin
                zero_reg <= zero_reg + 8'h01;
            end
        end else if (bit_en) begin
            if (!open_reg) begin
                if (mark) begin
                    open_reg <= 1'b1;
                    win_reg <= 7'h01;
                    ones_reg <= 4'h1;
                end
            end else if (ones_reg + 4'(mark) >= 4'(CARRIER_ONES)) begin
                loss <= 1'b0; // RULE4 RULE10
                open_reg <= 1'b0;
            end else begin
                ones_reg <= ones_reg + 4'(mark);
                win_reg <= win_reg + 7'h01;
                if (win_reg == 7'(CARRIER_WIN - 1)) begin
                    open_reg <= 1'b0;
                end
            end
        end
    end

    zero_run_a: assert property (@(posedge clk) disable iff (!nrst) // RULE4
        $rose(loss) |-> $past(zero_reg) == 8'(CARRIER_ZEROS - 1)
            && $past(!mark))
        else $error("carrier loss set without full zero run");
endmodule

/* File: logic/t1ras_pkg.sv */
// constants for the t1 receive alarm and status block
package t1ras_pkg;
    // register offsets on the parallel port
    localparam logic [7:0] RECEIVE_INFO_THREE_ADDR = 8'h10;
    localparam logic [7:0] ALARM_STATUS_ONE_ADDR = 8'h20;
    localparam logic [7:0] EVENT_STATUS_TWO_ADDR = 8'h21;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // bit positions in receive_info_three
    localparam int RX_LEVEL_HI_BIT = 7;
    localparam int RX_LEVEL_LO_BIT = 6;
    localparam int JITTER_LIMIT_TRIP_BIT = 5;
    localparam int RX_CLOCK_LOST_BIT = 4;
    localparam int FRAMER_CARRIER_LOSS_BIT = 3;
    localparam logic [7:0] INFO3_UNUSED_MASK = 8'h07;
    // alarm bits of alarm_status_one, bits 3..0
    localparam logic [7:0] STAT1_ALARM_MASK = 8'h0F;
    // timing
    localparam int CLK_MHZ = 40;
    localparam int RCLK_LOSS_NS = 3000;
    localparam int RCLK_LOSS_CYC = (RCLK_LOSS_NS * CLK_MHZ) / 1000;
    localparam int TCLK_LOSS_NS = 5200;
    localparam int TCLK_LOSS_CYC = (TCLK_LOSS_NS * CLK_MHZ) / 1000;
    localparam int BLUE_WIN_US = 3000;
    localparam int BLUE_WIN_CYC = BLUE_WIN_US * CLK_MHZ;
    localparam int SEC_BITS = 1544000;
    // detector thresholds
    localparam int CARRIER_ZEROS = 192;
    localparam int CARRIER_ONES = 14;
    localparam int CARRIER_WIN = 112;
    localparam int BLUE_SET_ZEROS = 5;
    localparam int YEL_CHANNELS = 256;
    localparam int YEL_ZEROS = 254;
    localparam logic [15:0] YEL_ESF_PATTERN = 16'h00FF;
    localparam int YEL_ESF_CLEAR = 14;
    localparam int ABORT_ONES = 8;
    localparam int JA_SMALL = 32;
    localparam int JA_LARGE = 128;
    localparam int JA_MARGIN = 4;
endpackage

/* File: logic/t1ras_top.sv */
// t1 receive alarm detection and latched status registers
// Operation
// RULE1: receive level reported in two-bit field
// RULE2: jitter flag when buffer within four bits
// RULE3: receive clock lost after about 3 us
// RULE4: framer carrier loss: 192 zeros, 14/112 clears
// RULE5: low three bits of info three unassigned
// RULE6: blue alarm on five or fewer zeros/3ms
// RULE7: yellow when bit2 zero 254 of 256
// RULE8: yellow on two twelfth framing bits one
// RULE9: esf yellow after sixteen 00FF link patterns
// RULE10: red alarm 192 zeros, 14 of 112 clears
// RULE11: blue detector tolerant, ignores framed all ones
// RULE12: host qualifies blue with sync loss
// RULE13: flags latch until read; alarms persist
// RULE14: mask write selects which bits refresh
// RULE15: alarm change drives interrupt until read
// RULE16: event drives interrupt until flag read
// RULE17: transmit clock lost after 5.2 us
// RULE18: one second tick and link abort detect
`timescale 1ns/1ps
module t1ras_top #(
    parameter int BLUE_WIN = t1ras_pkg::BLUE_WIN_CYC,
    parameter int SEC_LEN = t1ras_pkg::SEC_BITS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx_clock_in,
    input wire logic rx_positive_in,
    input wire logic rx_negative_in,
    input wire logic tx_clock_in,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    output logic int_n,
    input wire logic [1:0] rx_level,
    input wire logic [7:0] ja_fill,
    input wire logic ja_large,
    input wire logic line_bit_en,
    input wire logic line_mark,
    input wire logic rx_sync_loss,
    input wire logic esf_mode,
    input wire logic yellow_mode_select,
    input wire logic ch_strobe,
    input wire logic ch_bit2,
    input wire logic fbit12_strobe,
    input wire logic fbit12_val,
    input wire logic fdl_strobe,
    input wire logic fdl_bit,
    input wire logic loop_up_detect,
    input wire logic loop_down_detect,
    input wire logic rx_buffer_slip,
    input wire logic rx_multiframe_mark,
    input wire logic tx_multiframe_mark,
    input wire logic rx_link_buffer_full,
    input wire logic tx_link_buffer_empty,
    input wire logic rx_link_match,
    input wire logic rx_signaling_change,
    input wire logic [7:0] imr1,
    input wire logic [7:0] imr2
);
    import t1ras_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // pin synchronisers: first stage feeds only the second
    logic [22:0] s1_reg, s2_reg;
    logic [6:0] s3_reg;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_reg <= 23'h7FFFFF;
            s2_reg <= 23'h7FFFFF;
            s3_reg <= 7'h7F;
        end else begin
            s1_reg <= {rx_clock_in, rx_positive_in, rx_negative_in,
                tx_clock_in, cs_n, rd_n, wr_n, addr, data_in};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg[22:16];
        end
    end
    logic rclk_edge, tclk_edge, mark, cs_act, rd_fall, wr_fall;
    logic [7:0] a_s, d_s;
    assign rclk_edge = s2_reg[22] && !s3_reg[6];
    assign tclk_edge = s2_reg[19] != s3_reg[3];
    assign mark = s2_reg[21] || s2_reg[20];
    assign cs_act = !s2_reg[18];
    assign rd_fall = cs_act && !s2_reg[17] && s3_reg[1];
    assign wr_fall = cs_act && !s2_reg[16] && s3_reg[0];
    assign a_s = s2_reg[15:8];
    assign d_s = s2_reg[7:0];

    // clock loss timers
    logic [7:0] rtmr_reg, ttmr_reg;
    logic rclk_lost, tclk_lost;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rtmr_reg <= 8'h00;
            ttmr_reg <= 8'h00;
        end else begin
            if (rclk_edge) rtmr_reg <= 8'h00;
            else if (!rclk_lost) rtmr_reg <= rtmr_reg + 8'h01;
            if (tclk_edge) ttmr_reg <= 8'h00;
            else if (!tclk_lost) ttmr_reg <= ttmr_reg + 8'h01;
        end
    end
    assign rclk_lost = rtmr_reg >= 8'(RCLK_LOSS_CYC); // RULE3
    assign tclk_lost = ttmr_reg >= 8'(TCLK_LOSS_CYC); // RULE17

    // carrier loss detectors
    logic framer_carrier_loss, line_carrier_loss, jitter_limit_trip;
    t1ras_carrier u_framer (.clk(clk), .nrst(nrst), .bit_en(rclk_edge),
        .mark(mark), .loss(framer_carrier_loss));
    t1ras_carrier u_line (.clk(clk), .nrst(nrst), .bit_en(line_bit_en),
        .mark(line_mark), .loss(line_carrier_loss));

    // blue alarm: zeros per fixed window; framing bits keep it quiet
    logic [16:0] btmr_reg;
    logic [2:0] bz_reg;
    logic blue_reg, bwin_end;
    assign bwin_end = btmr_reg == 17'(BLUE_WIN - 1);
    always_ff @(posedge clk) begin
        if (!nrst) begin
            btmr_reg <= 17'h00000;
            bz_reg <= 3'h0;
            blue_reg <= 1'b0;
        end else if (bwin_end) begin
            btmr_reg <= 17'h00000;
            bz_reg <= 3'h0;
            blue_reg <= bz_reg <= 3'(BLUE_SET_ZEROS); // RULE6 RULE11
        end else begin
            btmr_reg <= btmr_reg + 17'h00001;
            if (rclk_edge && !mark && bz_reg != 3'(BLUE_SET_ZEROS + 1))
                bz_reg <= bz_reg + 3'h1;
        end
    end

    // yellow alarm in three modes
    logic [7:0] ych_reg;
    logic [8:0] yz_reg;
    logic f12_reg, yel_reg;
    logic [15:0] fsh_reg, hist_reg, hist_next;
    logic [3:0] fpos_reg;
    logic [4:0] hcount;
    always_comb begin
        hist_next = {hist_reg[14:0], {fsh_reg[14:0], fdl_bit}
            == YEL_ESF_PATTERN};
        hcount = 5'h00;
        for (int i = 0; i < 16; i++) hcount = hcount + 5'(hist_next[i]);
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ych_reg <= 8'h00;
            yz_reg <= 9'h000;
            f12_reg <= 1'b0;
            yel_reg <= 1'b0;
            fsh_reg <= 16'h0000;
            hist_reg <= 16'h0000;
            fpos_reg <= 4'h0;
        end else if (esf_mode) begin
            if (fdl_strobe) begin
                fsh_reg <= {fsh_reg[14:0], fdl_bit};
                fpos_reg <= fpos_reg + 4'h1;
                if (fpos_reg == 4'hF) begin
                    hist_reg <= hist_next;
                    if (hcount == 5'h10) yel_reg <= 1'b1; // RULE9
                    else if (hcount <= 5'(YEL_ESF_CLEAR))
                        yel_reg <= 1'b0; // RULE9
                end
            end
        end else if (yellow_mode_select) begin
            if (fbit12_strobe) begin
                f12_reg <= fbit12_val;
                if (fbit12_val && f12_reg) yel_reg <= 1'b1; // RULE8
                if (!fbit12_val && !f12_reg) yel_reg <= 1'b0; // RULE8
            end
        end else if (ch_strobe) begin
            ych_reg <= ych_reg + 8'h01;
            if (ych_reg == 8'(YEL_CHANNELS - 1)) begin
                yel_reg <= yz_reg + 9'(!ch_bit2) >= 9'(YEL_ZEROS); // RULE7
                yz_reg <= 9'h000;
            end else begin
                yz_reg <= yz_reg + 9'(!ch_bit2);
            end
        end
    end

    // one second tick and link abort
    logic [20:0] sec_reg;
    logic [3:0] ones_reg;
    logic sec_tick, abort_tick;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sec_reg <= 21'h000000;
            sec_tick <= 1'b0;
            ones_reg <= 4'h0;
            abort_tick <= 1'b0;
        end else begin
            sec_tick <= rclk_edge && sec_reg == 21'(SEC_LEN - 1); // RULE18
            if (rclk_edge)
                sec_reg <= sec_reg == 21'(SEC_LEN - 1) ? 21'h000000
                    : sec_reg + 21'h000001;
            abort_tick <= fdl_strobe && fdl_bit
                && ones_reg == 4'(ABORT_ONES - 1); // RULE18
            if (fdl_strobe)
                ones_reg <= !fdl_bit ? 4'h0 : ones_reg == 4'(ABORT_ONES)
                    ? ones_reg : ones_reg + 4'h1;
        end
    end

    // live status and latches
    logic [7:0] as1_live, es2_live, r3_live, as1_d;
    logic [7:0] as1_lat, es2_lat, r3_lat, as1_hold, es2_hold, r3_hold;
    logic [7:0] m1_reg, m2_reg, m3_reg, p1_reg, p2_reg, p1_set;
    logic [7:0] c1, c2, c3;
    logic [1:0] level_reg;
    assign jitter_limit_trip = ja_fill >= (ja_large
        ? 8'(JA_LARGE - JA_MARGIN) : 8'(JA_SMALL - JA_MARGIN)); // RULE2
    assign as1_live = {loop_up_detect, loop_down_detect, tclk_lost,
        rx_buffer_slip, blue_reg, yel_reg, line_carrier_loss, rx_sync_loss};
    assign es2_live = {rx_multiframe_mark, tx_multiframe_mark, sec_tick,
        rx_link_buffer_full, tx_link_buffer_empty, rx_link_match,
        abort_tick, rx_signaling_change};
    assign r3_live = {level_reg, jitter_limit_trip, rclk_lost,
        framer_carrier_loss, 3'b000};
    assign c1 = (rd_fall && a_s == ALARM_STATUS_ONE_ADDR)
        ? m1_reg & as1_hold : 8'h00;
    assign c2 = (rd_fall && a_s == EVENT_STATUS_TWO_ADDR)
        ? m2_reg & es2_hold : 8'h00;
    assign c3 = (rd_fall && a_s == RECEIVE_INFO_THREE_ADDR)
        ? m3_reg & r3_hold : 8'h00;
    assign p1_set = ((as1_live ^ as1_d) & STAT1_ALARM_MASK)
        | (as1_live & ~STAT1_ALARM_MASK);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            level_reg <= 2'b00;
            as1_d <= RESET_BYTE;
            as1_lat <= RESET_BYTE;
            es2_lat <= RESET_BYTE;
            r3_lat <= RESET_BYTE;
        end else begin
            level_reg <= rx_level; // RULE1
            as1_d <= as1_live;
            as1_lat <= (as1_lat & ~c1) | as1_live; // RULE13
            es2_lat <= (es2_lat & ~c2) | es2_live; // RULE13
            r3_lat <= (r3_lat & ~c3) | r3_live; // RULE13
        end
    end

    // mask write refreshes only selected bits of the read copy
    always_ff @(posedge clk) begin
        if (!nrst) begin
            m1_reg <= RESET_BYTE;
            m2_reg <= RESET_BYTE;
            m3_reg <= RESET_BYTE;
            as1_hold <= RESET_BYTE;
            es2_hold <= RESET_BYTE;
            r3_hold <= RESET_BYTE;
        end else if (wr_fall) begin
            case (a_s)
                ALARM_STATUS_ONE_ADDR: begin
                    m1_reg <= d_s;
                    as1_hold <= (as1_hold & ~d_s) | (as1_lat & d_s); // RULE14
                end
                EVENT_STATUS_TWO_ADDR: begin
                    m2_reg <= d_s;
                    es2_hold <= (es2_hold & ~d_s) | (es2_lat & d_s); // RULE14
                end
                RECEIVE_INFO_THREE_ADDR: begin
                    m3_reg <= d_s;
                    r3_hold <= (r3_hold & ~d_s)
                        | {r3_lat[7:3], 3'b000} & d_s; // RULE14 RULE5
                end
                default: begin
                end
            endcase
        end
    end

    // read port and interrupt
    always_ff @(posedge clk) begin
        if (!nrst) begin
            data_out <= RESET_BYTE;
            data_oe_n <= 1'b1;
            p1_reg <= RESET_BYTE;
            p2_reg <= RESET_BYTE;
            int_n <= 1'b1;
        end else begin
            data_oe_n <= !(cs_act && !s2_reg[17]);
            if (rd_fall) begin
                case (a_s)
                    ALARM_STATUS_ONE_ADDR: data_out <= as1_hold;
                    EVENT_STATUS_TWO_ADDR: data_out <= es2_hold;
                    RECEIVE_INFO_THREE_ADDR: data_out <= r3_hold; // RULE5
                    default: data_out <= RESET_BYTE;
                endcase
            end
            p1_reg <= (p1_reg & ~c1) | p1_set; // RULE15 RULE16
            p2_reg <= (p2_reg & ~c2) | es2_live; // RULE16
            int_n <= ~|((p1_reg & imr1) | (p2_reg & imr2)); // RULE15 RULE16
        end
    end

    level_copy_a: assert property ( // RULE1
        ##1 r3_live[RX_LEVEL_HI_BIT:RX_LEVEL_LO_BIT] == $past(rx_level))
        else $error("receive level field does not follow input");
    jitter_trip_a: assert property ( // RULE2
        ja_large && ja_fill >= 8'd124 |=> r3_lat[JITTER_LIMIT_TRIP_BIT])
        else $error("jitter trip flag not latched");
    rclk_loss_a: assert property ( // RULE3
        !rclk_edge [*8] ##0 rtmr_reg == 8'(RCLK_LOSS_CYC) |-> rclk_lost)
        else $error("receive clock loss not flagged");
    receive_info_three_low_a: assert property ( // RULE5
        rd_fall && a_s == RECEIVE_INFO_THREE_ADDR |=> data_out[2:0] == 3'b000)
        else $error("unassigned bits not zero");
    blue_set_a: assert property ( // RULE6
        bwin_end |=> blue_reg == ($past(bz_reg) <= 3'd5))
        else $error("blue alarm decision wrong");
    yel_f12_a: assert property ( // RULE8
        !esf_mode && yellow_mode_select && fbit12_strobe && fbit12_val
        && f12_reg |=> yel_reg)
        else $error("yellow not set on two framing ones");
    yel_esf_a: assert property ( // RULE9
        esf_mode && fdl_strobe && fpos_reg == 4'hF && hcount <= 5'd14
        |=> !yel_reg)
        else $error("esf yellow not cleared");
    alarm_hold_a: assert property ( // RULE13
        blue_reg [*2] |-> as1_lat[3] [*2])
        else $error("alarm flag dropped while alarm present");
    mask_keep_a: assert property ( // RULE14
        wr_fall && a_s == ALARM_STATUS_ONE_ADDR && d_s == 8'h00
        |=> $stable(as1_hold))
        else $error("unmasked bits refreshed");
    event_int_a: assert property ( // RULE16
        (es2_live & imr2) != 8'h00 ##1 $stable(imr2) |=> !int_n)
        else $error("event did not raise interrupt");
    tclk_loss_a: assert property ( // RULE17
        tclk_lost |-> ttmr_reg >= 8'd208)
        else $error("transmit clock loss early");
endmodule

/* File: testbench/t1ras_line_model.sv */
// line front end model: recovered clock, bipolar data, bit strobe
`timescale 1ns/1ps
module t1ras_line_model (
    input wire logic clk,
    output logic rx_clock_in,
    output logic rx_positive_in,
    output logic rx_negative_in,
    output logic line_bit_en,
    output logic line_mark
);
    logic pol;
    initial begin
        {rx_clock_in, rx_positive_in, rx_negative_in} = 3'h0;
        {line_bit_en, line_mark, pol} = 3'h0;
    end
    // n bits of v, inverted every per-th bit; clock still when idle
    task automatic send(input int n, input logic v, input int per);
        logic m;
        for (int i = 0; i < n; i++) begin
            m = (per != 0 && i % per == per - 1) ? ~v : v;
            @(posedge clk) #1;
            rx_positive_in = m & ~pol;
            rx_negative_in = m & pol;
            pol = pol ^ m;
            line_mark = m;
            @(posedge clk) #1;
            rx_clock_in = 1'b1;
            line_bit_en = 1'b1;
            @(posedge clk) #1;
            line_bit_en = 1'b0;
            repeat (3) @(posedge clk);
            #1 rx_clock_in = 1'b0;
            {rx_positive_in, rx_negative_in} = 2'h0;
        end
        @(posedge clk) #1;
    endtask
endmodule

/* File: testbench/t1ras_top_tb.sv */
// self-checking bench for the t1 receive alarm block
`timescale 1ns/1ps
module t1ras_top_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic tx_clock_in = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    logic [7:0] addr = 8'h00, data_in = 8'h00, ja_fill = 8'h00;
    logic [7:0] imr1 = 8'h00, imr2 = 8'h00;
    logic [1:0] rx_level = 2'h0;
    logic ja_large = 1'b0, sync_loss = 1'b0, esf = 1'b0, ysel = 1'b0;
    logic ch_s = 1'b0, ch_b = 1'b0, f12_s = 1'b0, f12_v = 1'b0;
    logic fdl_s = 1'b0, fdl_b = 1'b0, tx_run = 1'b1;
    logic [8:0] ev = 9'h000;
    logic [7:0] data_out;
    logic data_oe_n, int_n, rck, rp, rn, lbe, lm;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [7:0] ea [9] = '{8'h20, 8'h20, 8'h20, 8'h21, 8'h21, 8'h21,
        8'h21, 8'h21, 8'h21};
    int eb [9] = '{7, 6, 4, 7, 6, 4, 3, 2, 0};

    t1ras_line_model i_line (.clk(clk), .rx_clock_in(rck),
        .rx_positive_in(rp), .rx_negative_in(rn), .line_bit_en(lbe),
        .line_mark(lm));

    t1ras_top #(.BLUE_WIN(400), .SEC_LEN(50)) i_dut (.clk(clk),
        .nrst(nrst), .rx_clock_in(rck), .rx_positive_in(rp),
        .rx_negative_in(rn), .tx_clock_in(tx_clock_in), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .int_n(int_n),
        .rx_level(rx_level), .ja_fill(ja_fill), .ja_large(ja_large),
        .line_bit_en(lbe), .line_mark(lm), .rx_sync_loss(sync_loss),
        .esf_mode(esf), .yellow_mode_select(ysel), .ch_strobe(ch_s),
        .ch_bit2(ch_b), .fbit12_strobe(f12_s), .fbit12_val(f12_v),
        .fdl_strobe(fdl_s), .fdl_bit(fdl_b), .loop_up_detect(ev[0]),
        .loop_down_detect(ev[1]), .rx_buffer_slip(ev[2]),
        .rx_multiframe_mark(ev[3]), .tx_multiframe_mark(ev[4]),
        .rx_link_buffer_full(ev[5]), .tx_link_buffer_empty(ev[6]),
        .rx_link_match(ev[7]), .rx_signaling_change(ev[8]),
        .imr1(imr1), .imr2(imr2));

    always #12.5 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (tx_run && cyc % 8 == 0) begin
            tx_clock_in <= ~tx_clock_in;
        end
        if (cyc == 40000) begin
            bad_count++;
            $display("BAD %0t timeout", $time);
            conclude();
        end
    end

    task automatic conclude();
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] g, e, input string s);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t %s: got %h want %h", $time, s, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge clk) #1;
        {cs_n, wr_n, addr, data_in} = {2'h0, a, d};
        repeat (4) @(posedge clk);
        #1 {cs_n, wr_n} = 2'h3;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        {cs_n, rd_n, addr} = {2'h0, a};
        repeat (5) @(posedge clk);
        #1 d = data_out;
        cmp({7'h00, data_oe_n}, 8'h00, "read not driven");
        {cs_n, rd_n} = 2'h3;
        repeat (5) @(posedge clk);
        #1;
    endtask

    // mask write, read, compare only the refreshed positions
    task automatic chk(input logic [7:0] a, m, e, input string s);
        logic [7:0] d;
        wr(a, m);
        rd(a, d);
        cmp(d & m, e & m, s);
    endtask

    task automatic flush(input logic [7:0] a, m);
        logic [7:0] d;
        wr(a, m);
        rd(a, d);
    endtask

    task automatic link(input logic [15:0] p, input int n);
        for (int i = 0; i < 16 * n; i++) begin
            fdl_b = p[15 - i % 16];
            fdl_s = 1'b1;
            @(posedge clk) #1;
            fdl_s = 1'b0;
            @(posedge clk) #1;
        end
    endtask

    initial begin
        logic [7:0] d;
        logic [5:0] fv, fe;
        repeat (3) @(posedge clk);
        #1 nrst = 1'b1;
        chk(8'h20, 8'hFF, 8'h00, "reset sr1");
        rd(8'h55, d);
        cmp(d, 8'h00, "unmapped");
        for (int i = 0; i < 4; i++) begin
            rx_level = i[1:0];
            flush(8'h10, 8'hC0);
            chk(8'h10, 8'hC0, {i[1:0], 6'h00}, "level");
        end
        for (int j = 0; j < 4; j++) begin
            ja_large = j[1];
            ja_fill = (j[1] ? 8'h80 : 8'h20) - 8'h05 + {7'h00, j[0]};
            flush(8'h10, 8'h20);
            chk(8'h10, 8'h20, {2'h0, j[0], 5'h00}, "jitter");
        end
        i_line.send(4, 1'b1, 0);
        flush(8'h10, 8'h10);
        i_line.send(4, 1'b1, 0);
        repeat (70) @(posedge clk);
        i_line.send(4, 1'b1, 0);
        chk(8'h10, 8'h10, 8'h00, "rx clock short gap");
        repeat (200) @(posedge clk);
        chk(8'h10, 8'h10, 8'h10, "rx clock lost");
        imr1 = 8'h02;
        i_line.send(192, 1'b0, 192);
        chk(8'h10, 8'h08, 8'h00, "carrier 191");
        chk(8'h20, 8'h02, 8'h00, "red 191");
        i_line.send(192, 1'b0, 0);
        cmp({7'h00, int_n}, 8'h00, "int on red");
        chk(8'h10, 8'h08, 8'h08, "carrier 192");
        chk(8'h20, 8'h02, 8'h02, "red 192");
        cmp({7'h00, int_n}, 8'h01, "int after read");
        imr1 = 8'h00;
        i_line.send(13, 1'b1, 0);
        i_line.send(99, 1'b0, 0);
        chk(8'h20, 8'h02, 8'h02, "red 13 ones");
        i_line.send(14, 1'b1, 0);
        flush(8'h20, 8'h02);
        chk(8'h20, 8'h02, 8'h00, "red clear");
        flush(8'h10, 8'h08);
        chk(8'h10, 8'h08, 8'h00, "carrier clear");
        sync_loss = 1'b1;
        i_line.send(200, 1'b1, 0);
        chk(8'h20, 8'h09, 8'h09, "blue with sync");
        chk(8'h20, 8'h08, 8'h08, "blue persists");
        sync_loss = 1'b0;
        // check while zeros still arrive; an idle line re-arms blue
        fork
            i_line.send(200, 1'b1, 5);
            begin
                repeat (900) @(posedge clk);
                flush(8'h20, 8'h09);
                chk(8'h20, 8'h09, 8'h00, "blue clear");
            end
        join
        chk(8'h21, 8'h20, 8'h20, "second tick");
        flush(8'h20, 8'h20);
        chk(8'h20, 8'h20, 8'h00, "tx clock ok");
        tx_run = 1'b0;
        repeat (250) @(posedge clk);
        chk(8'h20, 8'h20, 8'h20, "tx clock lost");
        tx_run = 1'b1;
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 512; i++) begin
                ch_b = (i % (128 >> k) == (127 >> k));
                ch_s = 1'b1;
                @(posedge clk) #1;
                ch_s = 1'b0;
                @(posedge clk) #1;
            end
            flush(8'h20, 8'h04);
            chk(8'h20, 8'h04, {5'h00, ~k[0], 2'h0}, "bit2 yellow");
        end
        ysel = 1'b1;
        fv = 6'h0D;
        fe = 6'h18;
        for (int i = 0; i < 6; i++) begin
            f12_v = fv[i];
            f12_s = 1'b1;
            @(posedge clk) #1;
            f12_s = 1'b0;
            flush(8'h20, 8'h04);
            chk(8'h20, 8'h04, {5'h00, fe[i], 2'h0}, "f12 yellow");
        end
        ysel = 1'b0;
        esf = 1'b1;
        link(16'h00FF, 15);
        chk(8'h20, 8'h04, 8'h00, "esf 15");
        link(16'h00FF, 1);
        chk(8'h20, 8'h04, 8'h04, "esf 16");
        link(16'hFFFF, 1);
        link(16'h00FF, 15);
        chk(8'h20, 8'h04, 8'h04, "esf 15 of 16");
        link(16'hFFFF, 2);
        link(16'h00FF, 14);
        flush(8'h20, 8'h04);
        chk(8'h20, 8'h04, 8'h00, "esf 14 of 16");
        chk(8'h21, 8'h02, 8'h02, "link abort");
        imr1 = 8'hD0;
        imr2 = 8'hDF;
        flush(8'h20, 8'hFF);
        flush(8'h21, 8'hFF);
        for (int i = 0; i < 9; i++) begin
            ev[i] = 1'b1;
            @(posedge clk) #1;
            ev[i] = 1'b0;
            repeat (4) @(posedge clk);
            #1;
            cmp({7'h00, int_n}, 8'h00, "event int");
            wr(ea[i], 8'h00);
            rd(ea[i], d);
            cmp(d & (8'h01 << eb[i]), 8'h00, "mask held");
            chk(ea[i], 8'h01 << eb[i], 8'hFF, "event set");
            cmp({7'h00, int_n}, 8'h01, "event int off");
            chk(ea[i], 8'h01 << eb[i], 8'h00, "event clear");
        end
        conclude();
    end
endmodule
